// ### rtl/phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// four oscillator phases per instruction cycle
module phase_gen (
  input wire logic clk,
  input wire logic rst_b,
  output logic q2_en,
  output logic q4_en
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;

  always_comb begin
    phase_d = phase_q + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign q2_en = (phase_q == timer_pkg::PHASE_Q2);
  assign q4_en = (phase_q == timer_pkg::PHASE_Q4);
endmodule
`default_nettype wire

// ### rtl/prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// shared divider, no software path to its count
module prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic step,
  input wire logic [2:0] sel,
  output logic tap
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // synchronous stand-in for the ripple chain; each bit is a square wave
  always_comb begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (step) begin
      cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= timer_pkg::PRESC_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tap = cnt_q[sel];
endmodule
`default_nettype wire

// ### rtl/timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - source select clear: count one per instruction cycle without prescaler
// - after a count write, hold counting two instruction cycles, then resume
// - source, route and pin-drive-disable all set: count the external pin
// - edge select clear counts rising edges, set counts falling edges
// - source set, route clear: count comparator output internally
// - source and route set, pin drive on: comparator drives pin, counted back from it
// - assign bit clear gives prescaler to timer, set gives it to watchdog
// - timer prescale divides by two to the power ratio plus one
// - prescaler is an 8-bit counter with no software access
// - count writes clear the prescaler while it serves the timer
// - watchdog clear also clears the prescaler while it serves the watchdog
// - every reset clears the prescaler
// - external count sampled from prescaler output on phases two and four
// - prescaler output is a symmetric divided square wave
// - increment follows the synchronised prescaler output, adding latency
// - source select set overrides the count pin direction
// - count register is eight bits, readable and writable
// - source select clear uses instruction cycles whatever the routing
module timer_counter #(
  parameter int PRESC_W = 8,
  parameter int DIR_W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [timer_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [timer_pkg::ADDR_W-1:0] rd_addr,
  input wire logic option_wr,
  input wire logic [7:0] option_data,
  input wire logic dir_wr,
  input wire logic [DIR_W-1:0] dir_data,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_tick,
  input wire logic ext_count_pin,
  input wire logic comparator_result,
  output logic [7:0] rd_data_q,
  output logic [7:0] count_value_q,
  output logic [7:0] option_q,
  output logic [DIR_W-1:0] pin_dir_q,
  output logic comparator_out_pin_q,
  output logic comparator_out_pin_oe_q,
  output logic watchdog_post_tick_q
);
  // ==========================================
  // phases
  logic q2_en;
  logic q4_en;

  phase_gen u_phase (
    .clk(clk),
    .rst_b(rst_b),
    .q2_en(q2_en),
    .q4_en(q4_en)
  );

  // ==========================================
  // configuration registers
  logic [6:0] cmp_ctrl_q;
  logic [6:0] cmp_ctrl_d;
  logic [7:0] option_d;
  logic [DIR_W-1:0] dir_q;
  logic [DIR_W-1:0] dir_d;
  logic count_wr;
  logic cmp_wr;

  assign count_wr = wr_en && (wr_addr == timer_pkg::ADDR_COUNT_VALUE);
  assign cmp_wr = wr_en && (wr_addr == timer_pkg::ADDR_CMP_CTRL);

  always_comb begin
    option_d = option_q;
    cmp_ctrl_d = cmp_ctrl_q;
    dir_d = dir_q;
    if (option_wr) begin
      option_d = option_data;
    end
    // result bit is read-only, only the low seven bits are stored
    if (cmp_wr) begin
      cmp_ctrl_d = wr_data[6:0];
    end
    if (dir_wr) begin
      dir_d = dir_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      option_q <= timer_pkg::OPTION_RST;
      cmp_ctrl_q <= timer_pkg::CMP_CTRL_RST;
      dir_q <= timer_pkg::PIN_DIR_RST;
    end else begin
      option_q <= option_d;
      cmp_ctrl_q <= cmp_ctrl_d;
      dir_q <= dir_d;
    end
  end

  // ==========================================
  // decoded controls
  logic clock_source_select;
  logic source_edge_select;
  logic scaler_assign;
  logic [timer_pkg::RATIO_W-1:0] scale_ratio;
  logic cmp_on;
  logic comparator_clock_route;
  logic comparator_pin_drive_n;
  logic cmp_out;

  assign clock_source_select = option_q[timer_pkg::OPT_CLK_SRC];
  assign source_edge_select = option_q[timer_pkg::OPT_EDGE];
  assign scaler_assign = option_q[timer_pkg::OPT_ASSIGN];
  assign scale_ratio = option_q[timer_pkg::OPT_RATIO_LSB +: timer_pkg::RATIO_W];
  assign cmp_on = cmp_ctrl_q[timer_pkg::CMP_ON];
  // comparator off: its routing bits lose their effect
  assign comparator_clock_route = cmp_ctrl_q[timer_pkg::CMP_ROUTE] || !cmp_on;
  assign comparator_pin_drive_n = cmp_ctrl_q[timer_pkg::CMP_PIN_DRIVE_N] || !cmp_on;
  assign cmp_out = comparator_result ^ !cmp_ctrl_q[timer_pkg::CMP_POL];

  // ==========================================
  // count source selection
  timer_pkg::count_src_t src_sel;
  logic src_level;
  logic pin_driven;

  always_comb begin
    if (!clock_source_select) begin
      src_sel = timer_pkg::SRC_INSTR;
    end else if (!comparator_clock_route) begin
      src_sel = timer_pkg::SRC_CMP_INT;
    end else if (!comparator_pin_drive_n) begin
      src_sel = timer_pkg::SRC_CMP_PIN;
    end else begin
      src_sel = timer_pkg::SRC_PIN;
    end
  end

  assign pin_driven = (src_sel == timer_pkg::SRC_CMP_PIN);

  always_comb begin
    case (src_sel)
      timer_pkg::SRC_PIN: src_level = ext_count_pin;
      timer_pkg::SRC_CMP_INT: src_level = cmp_out;
      // pin input stays live while the comparator drives it
      timer_pkg::SRC_CMP_PIN: src_level = ext_count_pin;
      default: src_level = 1'b0;
    endcase
  end

  // ==========================================
  // edge detection ahead of the divider
  logic edge_level;
  logic edge_prev_q;
  logic edge_prev_d;
  logic src_step;
  logic presc_step;
  logic presc_clear;
  logic presc_tap;
  logic timer_owns;

  assign edge_level = src_level ^ source_edge_select;
  assign timer_owns = !scaler_assign;

  always_comb begin
    edge_prev_d = edge_level;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // reset high: a source idling at its counted level gives no false step
      edge_prev_q <= 1'b1;
    end else begin
      edge_prev_q <= edge_prev_d;
    end
  end

  always_comb begin
    if (src_sel == timer_pkg::SRC_INSTR) begin
      src_step = q4_en;
    end else begin
      src_step = edge_level && !edge_prev_q;
    end
  end

  // divider steps from one owner only, never both
  assign presc_step = timer_owns ? src_step : watchdog_tick;
  assign presc_clear = timer_owns ? count_wr : watchdog_clear_instr;

  // tap k gives a ratio of 2^(k+1)
  prescaler #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .clk(clk),
    .rst_b(rst_b),
    .clear(presc_clear),
    .step(presc_step),
    .sel(scale_ratio),
    .tap(presc_tap)
  );

  // ==========================================
  // synchronisation and increment request
  logic div_out;
  logic samp_q;
  logic samp_d;
  logic tap_prev_q;
  logic tap_prev_d;
  logic tap_rise;
  logic samp_rise;
  logic inc_req;

  // without prescaler the raw edge-adjusted level stands in for its output
  assign div_out = timer_owns ? presc_tap : edge_level;
  assign tap_rise = presc_tap && !tap_prev_q;
  assign samp_rise = (q2_en || q4_en) && div_out && !samp_q;

  always_comb begin
    tap_prev_d = presc_tap;
    samp_d = samp_q;
    if (q2_en || q4_en) begin
      samp_d = div_out;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_prev_q <= 1'b0;
      samp_q <= 1'b1;
    end else begin
      tap_prev_q <= tap_prev_d;
      samp_q <= samp_d;
    end
  end

  // pin timing limits are the source's duty, sampling relies on them
  always_comb begin
    if (src_sel == timer_pkg::SRC_INSTR) begin
      inc_req = timer_owns ? tap_rise : q4_en;
    end else begin
      inc_req = samp_rise;
    end
  end

  // ==========================================
  // count register and write inhibit
  logic [1:0] inhibit_q;
  logic [1:0] inhibit_d;
  logic [7:0] count_d;
  logic inc_pend_q;
  logic inc_pend_d;

  always_comb begin
    inhibit_d = inhibit_q;
    if (count_wr) begin
      inhibit_d = timer_pkg::INHIBIT_CYCLES;
    end else if (q4_en && (inhibit_q != 2'h0)) begin
      inhibit_d = inhibit_q - 2'h1;
    end
  end

  // one clock of pipeline after the sampled edge, as the phase latency
  always_comb begin
    inc_pend_d = inc_req && (inhibit_q == 2'h0) && !count_wr;
  end

  always_comb begin
    count_d = count_value_q;
    if (count_wr) begin
      count_d = wr_data;
    end else if (inc_pend_q && (inhibit_q == 2'h0)) begin
      count_d = count_value_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inhibit_q <= 2'h0;
      inc_pend_q <= 1'b0;
      count_value_q <= timer_pkg::COUNT_RST;
    end else begin
      inhibit_q <= inhibit_d;
      inc_pend_q <= inc_pend_d;
      count_value_q <= count_d;
    end
  end

  // ==========================================
  // pins and watchdog tap
  logic [DIR_W-1:0] pin_dir_d;
  logic cmp_pin_d;
  logic cmp_oe_d;
  logic wdt_d;

  always_comb begin
    pin_dir_d = dir_q;
    if (pin_driven) begin
      pin_dir_d[timer_pkg::COUNT_PIN_IDX] = 1'b0;
    end else if (clock_source_select) begin
      pin_dir_d[timer_pkg::COUNT_PIN_IDX] = 1'b1;
    end
    cmp_pin_d = pin_driven && cmp_out;
    cmp_oe_d = pin_driven;
    wdt_d = scaler_assign && tap_rise;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_dir_q <= timer_pkg::PIN_DIR_RST;
      comparator_out_pin_q <= 1'b0;
      comparator_out_pin_oe_q <= 1'b0;
      watchdog_post_tick_q <= 1'b0;
    end else begin
      pin_dir_q <= pin_dir_d;
      comparator_out_pin_q <= cmp_pin_d;
      comparator_out_pin_oe_q <= cmp_oe_d;
      watchdog_post_tick_q <= wdt_d;
    end
  end

  // ==========================================
  // read port
  logic [7:0] rd_data_d;

  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en) begin
      case (rd_addr)
        timer_pkg::ADDR_COUNT_VALUE: rd_data_d = count_value_q;
        timer_pkg::ADDR_CMP_CTRL: rd_data_d = {cmp_out, cmp_ctrl_q};
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end
endmodule
`default_nettype wire

// ### rtl/timer_pkg.sv
// ==========================================
// register map
package timer_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_COUNT_VALUE = 5'h01;
  localparam logic [4:0] ADDR_CMP_CTRL = 5'h07;

  // ==========================================
  // field positions, timer_prescale_config
  localparam int OPT_CLK_SRC = 5;
  localparam int OPT_EDGE = 4;
  localparam int OPT_ASSIGN = 3;
  localparam int OPT_RATIO_LSB = 0;
  localparam int RATIO_W = 3;

  // ==========================================
  // field positions, comparator_control
  localparam int CMP_RESULT = 7;
  localparam int CMP_PIN_DRIVE_N = 6;
  localparam int CMP_POL = 5;
  localparam int CMP_ROUTE = 4;
  localparam int CMP_ON = 3;

  // ==========================================
  // reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [6:0] CMP_CTRL_RST = 7'h7F;
  localparam logic [3:0] PIN_DIR_RST = 4'hF;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // ==========================================
  // timing
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam int COUNT_PIN_IDX = 2;

  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_PIN = 2'b01,
    SRC_CMP_INT = 2'b10,
    SRC_CMP_PIN = 2'b11
  } count_src_t;
endpackage

// ### testbench/count_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// far side: count pin source and comparator output
module count_source_model (
  input wire logic clk,
  input wire logic comparator_out_pin_oe_q,
  input wire logic comparator_out_pin_q,
  output logic ext_count_pin,
  output logic comparator_result
);
  logic pin_src = 1'b0;
  // the device owns the shared pin while it drives it
  assign ext_count_pin = comparator_out_pin_oe_q ? comparator_out_pin_q : pin_src;
  initial comparator_result = 1'b0;
  task automatic level(input bit cmp, input bit v);
    @(posedge clk);
    #1;
    if (cmp) comparator_result = v;
    else pin_src = v;
  endtask
  // half period in clocks, two at the least, so sampling never misses a level
  task automatic pulses(input bit cmp, input int n, input int half);
    repeat (n) begin
      level(cmp, 1'b1);
      repeat (half - 1) @(posedge clk);
      level(cmp, 1'b0);
      repeat (half - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/test_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
// ==========
// bench top
module test_timer_counter;
  logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, option_wr = 1'b0;
  logic dir_wr = 1'b0, watchdog_clear_instr = 1'b0, watchdog_tick = 1'b0;
  logic [timer_pkg::ADDR_W-1:0] wr_addr = 5'h00, rd_addr = 5'h00;
  logic [7:0] wr_data = 8'h00, option_data = 8'h00, rd_data_q, count_value_q, option_q;
  logic [3:0] dir_data = 4'h0, pin_dir_q;
  logic comparator_out_pin_q, comparator_out_pin_oe_q, watchdog_post_tick_q;
  logic ext_count_pin, comparator_result;
  int errors = 0, check_count = 0, post_seen = 0;

  always #4 clk = ~clk;
  always @(posedge clk) if (watchdog_post_tick_q === 1'b1) post_seen++;
  timer_counter u_dut (.*);
  count_source_model u_src (.*);

  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    tick();
    {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    tick();
    wr_en = 1'b0;
  endtask
  task automatic opt(input logic [7:0] d);
    tick();
    {option_wr, option_data} = {1'b1, d};
    tick();
    option_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    tick();
    {rd_en, rd_addr} = {1'b1, a};
    tick();
    rd_en = 1'b0;
    d = rd_data_q;
  endtask
  task automatic wait_inc(output int n);
    logic [7:0] v;
    v = count_value_q;
    n = 0;
    while (count_value_q === v && n < 2100) begin
      tick();
      n++;
    end
  endtask
  task automatic wtick(input int n, input bit clr);
    tick();
    watchdog_clear_instr = clr;
    tick();
    watchdog_clear_instr = 1'b0;
    repeat (n) begin
      watchdog_tick = 1'b1;
      tick();
      watchdog_tick = 1'b0;
      tick();
    end
    tick(4);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    `CHK(option_q, 8'hFF)
    `CHK(pin_dir_q, 4'hF)
    `CHK(count_value_q, 8'h00)
    `CHK(comparator_out_pin_oe_q, 1'b0)
    rd(5'h07, d);
    `CHK(d, 8'h7F)
    rd(5'h02, d);
    `CHK(d, 8'h00)
    {dir_wr, dir_data} = {1'b1, 4'hA};
    tick();
    dir_wr = 1'b0;
    tick();
    `CHK(pin_dir_q, 4'hE)
    // falling edge selected with the pin low: no step may follow reset
    `CHK(count_value_q, 8'h00)
  endtask
  task automatic t_timer();
    int n;
    logic [7:0] d;
    opt(8'h08);
    wr(5'h07, 8'h28);
    `CHK(pin_dir_q, 4'hA)
    wr(5'h01, 8'hFE);
    tick(8);
    `CHK(count_value_q, 8'hFE)
    wait_inc(n);
    `CHK(count_value_q, 8'hFF)
    wait_inc(n);
    `CHK(n, 4)
    `CHK(count_value_q, 8'h00)
    rd(5'h01, d);
    `CHK(d, 8'h00)
  endtask
  task automatic t_prescale();
    int n;
    for (int k = 0; k < 8; k++) begin
      opt(8'(k));
      wait_inc(n);
      wait_inc(n);
      `CHK(n, 8 << k)
    end
    wait_inc(n);
    tick(600);
    // a stale prescaler would step the count well before 500 clocks
    wr(5'h01, 8'h40);
    wait_inc(n);
    `CHK(n > 500 && n < 530, 1'b1)
  endtask
  task automatic pin_step(input bit v, input logic [7:0] exp);
    u_src.level(1'b0, v);
    tick(8);
    `CHK(count_value_q, exp)
  endtask
  task automatic t_pin();
    opt(8'h28);
    wr(5'h07, 8'h7F);
    wr(5'h01, 8'h00);
    tick(16);
    `CHK(comparator_out_pin_oe_q, 1'b0)
    `CHK(pin_dir_q, 4'hE)
    pin_step(1'b1, 8'h01);
    pin_step(1'b0, 8'h01);
    pin_step(1'b1, 8'h02);
    opt(8'h38);
    pin_step(1'b0, 8'h03);
    pin_step(1'b1, 8'h03);
    u_src.pulses(1'b0, 5, 2);
    tick(8);
    `CHK(count_value_q, 8'h08)
    // counter mode through the divide-by-two tap
    opt(8'h20);
    wr(5'h01, 8'h00);
    tick(16);
    u_src.pulses(1'b0, 4, 2);
    tick(8);
    `CHK(count_value_q, 8'h02)
  endtask
  task automatic t_cmp();
    logic [7:0] d;
    opt(8'h28);
    for (int i = 0; i < 2; i++) begin
      wr(5'h07, i ? 8'h0F : 8'h6F);
      wr(5'h01, 8'h00);
      tick(16);
      u_src.pulses(1'b1, 3, 2);
      u_src.pulses(1'b0, 2, 2);
      tick(8);
      `CHK(count_value_q, 8'h03)
    end
    // comparator off: routing bits lose effect, the pin counts
    wr(5'h07, 8'h27);
    wr(5'h01, 8'h00);
    tick(16);
    u_src.pulses(1'b1, 2, 2);
    u_src.pulses(1'b0, 3, 2);
    tick(8);
    `CHK(count_value_q, 8'h03)
    wr(5'h07, 8'h3F);
    wr(5'h01, 8'h00);
    tick(16);
    `CHK(comparator_out_pin_oe_q, 1'b1)
    `CHK(pin_dir_q, 4'hA)
    u_src.pulses(1'b1, 4, 3);
    tick(8);
    `CHK(count_value_q, 8'h04)
    rd(5'h07, d);
    `CHK(d, 8'h3F)
    u_src.level(1'b1, 1'b1);
    rd(5'h07, d);
    `CHK(d, 8'hBF)
    `CHK(comparator_out_pin_q, 1'b1)
    u_src.level(1'b1, 1'b0);
    tick(2);
    `CHK(comparator_out_pin_q, 1'b0)
  endtask
  task automatic t_wdt();
    int p;
    wtick(0, 1'b1);
    opt(8'h00);
    p = post_seen;
    wtick(4, 1'b0);
    `CHK(post_seen - p, 0)
    wtick(0, 1'b1);
    wr(5'h01, 8'h00);
    opt(8'h0F);
    wtick(0, 1'b1);
    opt(8'h08);
    p = post_seen;
    wtick(4, 1'b0);
    `CHK(post_seen - p, 2)
    wtick(1, 1'b0);
    wtick(1, 1'b1);
    `CHK(post_seen - p, 4)
  endtask

  initial begin
    tick(5);
    rst_b = 1'b1;
    t_reset();
    t_timer();
    t_prescale();
    t_pin();
    t_cmp();
    t_wdt();
    rst_b = 1'b0;
    tick(5);
    rst_b = 1'b1;
    t_reset();
    tally_and_finish();
  end
  // whole run is near 5200 clocks
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### testbench/timer_counter_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port-level checks
module timer_counter_checker #(
  parameter int DIR_W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [timer_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [timer_pkg::ADDR_W-1:0] rd_addr,
  input wire logic option_wr,
  input wire logic [7:0] option_data,
  input wire logic [7:0] rd_data_q,
  input wire logic [7:0] count_value_q,
  input wire logic [7:0] option_q,
  input wire logic [DIR_W-1:0] pin_dir_q,
  input wire logic comparator_out_pin_oe_q,
  input wire logic watchdog_post_tick_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic cnt_wr;
  logic tmode;
  assign cnt_wr = wr_en && wr_addr == timer_pkg::ADDR_COUNT_VALUE;
  // plain timer mode, prescaler away at the watchdog
  assign tmode = !option_q[timer_pkg::OPT_CLK_SRC] && option_q[timer_pkg::OPT_ASSIGN];

  chk_write_load: assert property (cnt_wr |=> count_value_q == $past(wr_data))
    else $error("count write not loaded");
  chk_write_hold: assert property (cnt_wr ##1 !cnt_wr [*7] |-> $stable(count_value_q))
    else $error("count moved during write hold-off");
  chk_step_one: assert property (
    count_value_q != $past(count_value_q) && !$past(cnt_wr)
    |-> count_value_q == 8'($past(count_value_q) + 8'h01))
    else $error("count moved by other than one");
  // a fresh mode switch may still carry a pending step, so look back
  chk_timer_rate: assert property (
    tmode && $past(tmode, 4) && !$past(cnt_wr)
    && count_value_q != $past(count_value_q) ##1 (tmode && !cnt_wr) [*4]
    |-> count_value_q == 8'($past(count_value_q, 4) + 8'h01))
    else $error("timer step not every four clocks");
  chk_read_count: assert property (
    rd_en && rd_addr == timer_pkg::ADDR_COUNT_VALUE
    |=> rd_data_q == $past(count_value_q))
    else $error("count read wrong");
  chk_read_hold: assert property (!rd_en |=> $stable(rd_data_q))
    else $error("read data changed without read");
  chk_option_load: assert property (option_wr |=> option_q == $past(option_data))
    else $error("option write not loaded");
  chk_dir_force: assert property (
    option_q[timer_pkg::OPT_CLK_SRC] && !comparator_out_pin_oe_q
    && $stable(option_q) && $stable(comparator_out_pin_oe_q)
    |-> pin_dir_q[timer_pkg::COUNT_PIN_IDX])
    else $error("count pin direction not overridden");
  chk_drive_dir: assert property (
    comparator_out_pin_oe_q && $past(comparator_out_pin_oe_q)
    |-> !pin_dir_q[timer_pkg::COUNT_PIN_IDX])
    else $error("driven pin still input");
  chk_post_timer: assert property (
    !option_q[timer_pkg::OPT_ASSIGN] [*3]
    |-> !watchdog_post_tick_q)
    else $error("watchdog tick while timer owns prescaler");
  chk_post_gap: assert property (watchdog_post_tick_q |=> !watchdog_post_tick_q)
    else $error("postscale tick too close");
endmodule

bind timer_counter timer_counter_checker #(.DIR_W(DIR_W)) u_chk (.*);
`default_nettype wire
